// *** hdl/rffr_fault_response.v ***
// Fault-response logic for the six-volt rail, flyback overcurrent, flyback
// switch short and average overcurrent faults, with its byte registers.
// Assumes fault detectors and enable pins are asynchronous to clk and that
// the register port is driven by logic on clk.
//
// Notes on behaviour
// - Per-fault fields apply only while the override bit is 1, otherwise the strapped mode decides, except that a short then always halts.
// - Six-volt overvoltage field bits 5:4 decode 00 flag, 01 hiccup, 10 latch-off, 11 flag.
// - Six-volt overvoltage sets rail status bit 0 and pulls the alert low under any response.
// - Six-volt undervoltage field bits 7:6 use the same decoding.
// - Six-volt undervoltage sets rail status bit 1 and pulls the alert low.
// - Flag-only records status and asserts the alert while switching continues.
// - Hiccup on a six-volt fault stops PWM and restarts it 500 ms after the fault clears.
// - Latch-off on a six-volt fault stops PWM until PWM enable or chip enable is toggled.
// - Flyback overcurrent field bits 1:0 decode alike and set rail status bit 4 and the alert.
// - Flyback overcurrent hiccup stops flyback and PWM, restarting flyback 500 ms after clearing.
// - Flyback overcurrent latch-off holds flyback stopped until chip enable is toggled, and PWM until PWM enable rises after that.
// - The flyback register holds short control at 7, average field at 5:4, flyback field at 1:0.
// - Each response register is one byte, read/write, write-protectable and resets to zero.
// - Average overcurrent uses the same decoding and sets current status bit 5 and the alert.
// - Short control 0 halts all switching and drives system fail low until chip enable toggles; PWM also awaits a PWM enable rise.
`timescale 1ns/100ps
`include "rffr_defs.vh"

module rffr_fault_response #(
	parameter HICCUP_CYCLES = `RFFR_HICCUP_MS * 1000 * `RFFR_CLK_MHZ
) (
	input  wire       clk,
	input  wire       reset,
	input  wire       clkEnable,
	input  wire       sixVoltOver,
	input  wire       sixVoltUnder,
	input  wire       flybackOver,
	input  wire       avgOverCurrent,
	input  wire       flybackShort,
	input  wire       pwmEnablePin,
	input  wire       chipEnablePin,
	input  wire [1:0] modeStrap,
	input  wire       writeProtect,
	input  wire [7:0] regAddr,
	input  wire [7:0] regWrData,
	input  wire       regWrite,
	input  wire       regRead,
	output reg  [7:0] regRdData,
	output reg        pwmRun,
	output reg        flybackRun,
	output reg        fault_alert_n,
	output reg        system_fail_n
);

	// 27 bits hold the full 500 ms count at 200 MHz; the cut is deliberate
	localparam integer HICCUP_LAST_INT = HICCUP_CYCLES - 1;
	localparam [26:0]  HICCUP_LAST     = HICCUP_LAST_INT[26:0];

	// Response selection shared by all four configurable faults
	function [1:0] respAct;
		input       ovr;
		input [1:0] field;
		input [1:0] strap;
		reg   [1:0] code;
		begin
			code = ovr ? field : strap;
			case (code)
				2'h1:    respAct = `RFFR_ACT_HICCUP;
				2'h2:    respAct = `RFFR_ACT_LATCH;
				default: respAct = `RFFR_ACT_FLAG; // 00 and 11 both flag only
			endcase
		end
	endfunction

	// Pin inputs pass two flip-flops; only stage two is read
	reg  [8:0] pinMeta_reg;
	reg  [8:0] pinSync_reg;
	wire       sixOv    = pinSync_reg[0];
	wire       sixUv    = pinSync_reg[1];
	wire       flyOc    = pinSync_reg[2];
	wire       avgOc    = pinSync_reg[3];
	wire       flyShort = pinSync_reg[4];
	wire       pwmEnIn  = pinSync_reg[5];
	wire       chipEnIn = pinSync_reg[6];
	wire [1:0] strapIn  = pinSync_reg[8:7];

	reg        override_reg;
	reg  [7:0] railsCfg_reg;
	reg  [7:0] flyAvgCfg_reg;
	reg  [7:0] railStatus_reg;
	reg  [7:0] currStatus_reg;
	reg  [7:0] flyStatus_reg;
	reg        pwmEnPrev_reg;
	reg        pwmLatch_reg;
	reg        flyLatch_reg;
	reg        shortLatch_reg;
	reg        pwmHiccup_reg;
	reg        flyHiccup_reg;
	reg [26:0] pwmTimer_reg;
	reg [26:0] flyTimer_reg;

	wire [1:0] actSixOv = respAct(override_reg, railsCfg_reg[`RFFR_SIX_OV_LSB +: 2], strapIn);
	wire [1:0] actSixUv = respAct(override_reg, railsCfg_reg[`RFFR_SIX_UV_LSB +: 2], strapIn);
	wire [1:0] actFlyOc = respAct(override_reg, flyAvgCfg_reg[`RFFR_FLY_OC_LSB +: 2], strapIn);
	wire [1:0] actAvgOc = respAct(override_reg, flyAvgCfg_reg[`RFFR_AVG_OC_LSB +: 2], strapIn);
	// Without override the short is treated as its default, a full halt
	wire       shortFlagOnly = override_reg & flyAvgCfg_reg[`RFFR_FLY_SHORT_BIT];

	// Conditions currently asking for a PWM or flyback hiccup, latch-off or short halt
	wire pwmHiccupCond = (sixOv & (actSixOv == `RFFR_ACT_HICCUP)) |
	                     (sixUv & (actSixUv == `RFFR_ACT_HICCUP)) |
	                     (avgOc & (actAvgOc == `RFFR_ACT_HICCUP));
	wire pwmLatchCond  = (sixOv & (actSixOv == `RFFR_ACT_LATCH)) |
	                     (sixUv & (actSixUv == `RFFR_ACT_LATCH)) |
	                     (avgOc & (actAvgOc == `RFFR_ACT_LATCH));
	wire flyHiccupCond = flyOc & (actFlyOc == `RFFR_ACT_HICCUP);
	wire flyLatchCond  = flyOc & (actFlyOc == `RFFR_ACT_LATCH);
	wire shortHaltCond = flyShort & ~shortFlagOnly;

	// A low chip enable releases every latch; a low PWM enable releases PWM latch only
	wire chipOff  = ~chipEnIn;
	wire pwmOff   = ~pwmEnIn;
	wire pwmRise  = pwmEnIn & ~pwmEnPrev_reg;

	wire wrOk     = regWrite & ~writeProtect;
	wire wrRails  = wrOk & (regAddr == `RFFR_ADDR_RAILS_CFG);
	wire wrFlyAvg = wrOk & (regAddr == `RFFR_ADDR_FLYAVG_CFG);
	wire wrOvr    = wrOk & (regAddr == `RFFR_ADDR_OVERRIDE);
	// Status clear is write-one-to-clear and not subject to protection
	wire clrRail  = regWrite & (regAddr == `RFFR_ADDR_RAIL_STATUS);
	wire clrCurr  = regWrite & (regAddr == `RFFR_ADDR_CURR_STATUS);
	wire clrFly   = regWrite & (regAddr == `RFFR_ADDR_FLY_STATUS);

	reg [7:0] railStatus_next;
	reg [7:0] currStatus_next;
	reg [7:0] flyStatus_next;
	reg [7:0] rdMux;

	always @* begin
		railStatus_next = railStatus_reg & ~(clrRail ? regWrData : 8'h00);
		currStatus_next = currStatus_reg & ~(clrCurr ? regWrData : 8'h00);
		flyStatus_next  = flyStatus_reg & ~(clrFly ? regWrData : 8'h00);
		// Sets are applied after clears so a coincident event is kept
		if (sixOv) begin
			railStatus_next[`RFFR_ST_SIX_OV_BIT] = 1'b1;
		end
		if (sixUv) begin
			railStatus_next[`RFFR_ST_SIX_UV_BIT] = 1'b1;
		end
		if (flyOc) begin
			railStatus_next[`RFFR_ST_FLY_OC_BIT] = 1'b1;
		end
		if (avgOc) begin
			currStatus_next[`RFFR_ST_AVG_OC_BIT] = 1'b1;
		end
		if (flyShort) begin
			flyStatus_next[`RFFR_ST_FLY_SHORT_BIT] = 1'b1;
		end
	end

	always @* begin
		case (regAddr)
			`RFFR_ADDR_OVERRIDE:    rdMux = {override_reg, 7'h00};
			`RFFR_ADDR_RAILS_CFG:   rdMux = railsCfg_reg;
			`RFFR_ADDR_FLYAVG_CFG:  rdMux = flyAvgCfg_reg;
			`RFFR_ADDR_RAIL_STATUS: rdMux = railStatus_reg;
			`RFFR_ADDR_CURR_STATUS: rdMux = currStatus_reg;
			`RFFR_ADDR_FLY_STATUS:  rdMux = flyStatus_reg;
			default:                rdMux = 8'h00;
		endcase
	end

	always @(posedge clk) begin
		if (reset) begin
			pinMeta_reg <= 9'h000;
			pinSync_reg <= 9'h000;
		end else if (clkEnable) begin
			pinMeta_reg <= {modeStrap, chipEnablePin, pwmEnablePin, flybackShort,
			                avgOverCurrent, flybackOver, sixVoltUnder, sixVoltOver};
			pinSync_reg <= pinMeta_reg;
		end
	end

	// Register file
	always @(posedge clk) begin
		if (reset) begin
			override_reg   <= 1'b0;
			railsCfg_reg   <= `RFFR_CFG_RESET;
			flyAvgCfg_reg  <= `RFFR_CFG_RESET;
			railStatus_reg <= 8'h00;
			currStatus_reg <= 8'h00;
			flyStatus_reg  <= 8'h00;
			regRdData      <= 8'h00;
		end else if (clkEnable) begin
			if (wrOvr) begin
				override_reg <= regWrData[`RFFR_OVERRIDE_BIT];
			end
			if (wrRails) begin
				railsCfg_reg <= regWrData;
			end
			if (wrFlyAvg) begin
				flyAvgCfg_reg <= regWrData & `RFFR_FLYAVG_WMASK; // Reserved bits 6, 3, 2 read zero
			end
			railStatus_reg <= railStatus_next;
			currStatus_reg <= currStatus_next;
			flyStatus_reg  <= flyStatus_next;
			if (regRead) begin
				regRdData <= rdMux;
			end
		end
	end

	// PWM-side hiccup: the wait only starts once every hiccup condition is gone
	always @(posedge clk) begin
		if (reset) begin
			pwmHiccup_reg <= 1'b0;
			pwmTimer_reg  <= 27'h0000000;
		end else if (clkEnable) begin
			if (pwmHiccupCond) begin
				pwmHiccup_reg <= 1'b1;
				pwmTimer_reg  <= 27'h0000000;
			end else if (pwmHiccup_reg) begin
				if (pwmTimer_reg == HICCUP_LAST) begin
					pwmHiccup_reg <= 1'b0;
					pwmTimer_reg  <= 27'h0000000;
				end else begin
					pwmTimer_reg <= pwmTimer_reg + 27'h0000001;
				end
			end
		end
	end

	// Flyback-side hiccup, same timing as the PWM one
	always @(posedge clk) begin
		if (reset) begin
			flyHiccup_reg <= 1'b0;
			flyTimer_reg  <= 27'h0000000;
		end else if (clkEnable) begin
			if (flyHiccupCond) begin
				flyHiccup_reg <= 1'b1;
				flyTimer_reg  <= 27'h0000000;
			end else if (flyHiccup_reg) begin
				if (flyTimer_reg == HICCUP_LAST) begin
					flyHiccup_reg <= 1'b0;
					flyTimer_reg  <= 27'h0000000;
				end else begin
					flyTimer_reg <= flyTimer_reg + 27'h0000001;
				end
			end
		end
	end

	// Latch-off holds; a fault still present keeps its latch set over a release
	always @(posedge clk) begin
		if (reset) begin
			pwmLatch_reg   <= 1'b0;
			flyLatch_reg   <= 1'b0;
			shortLatch_reg <= 1'b0;
			pwmEnPrev_reg  <= 1'b0;
		end else if (clkEnable) begin
			pwmEnPrev_reg <= pwmEnIn;
			if (pwmLatchCond) begin
				pwmLatch_reg <= 1'b1;
			end else if (pwmOff | chipOff) begin
				pwmLatch_reg <= 1'b0;
			end
			if (flyLatchCond) begin
				flyLatch_reg <= 1'b1;
			end else if (chipOff) begin
				flyLatch_reg <= 1'b0;
			end
			if (shortHaltCond) begin
				shortLatch_reg <= 1'b1;
			end else if (chipOff) begin
				shortLatch_reg <= 1'b0;
			end
		end
	end

	// Outputs; PWM after a latched flyback stop needs a fresh PWM enable edge
	reg pwmBlocked_reg;
	wire flyStop = chipOff | flyHiccup_reg | flyHiccupCond | flyLatch_reg | flyLatchCond |
	               shortLatch_reg | shortHaltCond;
	wire pwmStop = flyStop | pwmOff | pwmHiccup_reg | pwmHiccupCond | pwmLatch_reg |
	               pwmLatchCond | pwmBlocked_reg;

	always @(posedge clk) begin
		if (reset) begin
			pwmBlocked_reg <= 1'b0;
			pwmRun         <= 1'b0;
			flybackRun     <= 1'b0;
			fault_alert_n  <= 1'b1;
			system_fail_n  <= 1'b1;
		end else if (clkEnable) begin
			// Latched flyback stop: PWM waits for enable to be driven high again
			if (flyLatch_reg | shortLatch_reg) begin
				pwmBlocked_reg <= 1'b1;
			end else if (pwmRise) begin
				pwmBlocked_reg <= 1'b0;
			end
			flybackRun    <= ~flyStop;
			pwmRun        <= ~pwmStop;
			fault_alert_n <= ~(|railStatus_next | |currStatus_next | |flyStatus_next);
			system_fail_n <= ~(shortLatch_reg | shortHaltCond);
		end
	end

endmodule

// *** hdl/rffr_defs.vh ***
// Constants for the rail and flyback fault-response block.
// Assumes byte-wide registers addressed by 8-bit command codes.
`ifndef RFFR_DEFS_VH
`define RFFR_DEFS_VH

// Register command codes
`define RFFR_ADDR_OVERRIDE      8'hB0
`define RFFR_ADDR_RAILS_CFG     8'hB3
`define RFFR_ADDR_FLYAVG_CFG    8'hB4
`define RFFR_ADDR_RAIL_STATUS   8'hD3
`define RFFR_ADDR_CURR_STATUS   8'hD5
`define RFFR_ADDR_FLY_STATUS    8'hD8

// Field positions
`define RFFR_OVERRIDE_BIT       7
`define RFFR_SIX_OV_LSB         4
`define RFFR_SIX_UV_LSB         6
`define RFFR_FLY_OC_LSB         0
`define RFFR_AVG_OC_LSB         4
`define RFFR_FLY_SHORT_BIT      7
`define RFFR_ST_SIX_OV_BIT      0
`define RFFR_ST_SIX_UV_BIT      1
`define RFFR_ST_FLY_OC_BIT      4
`define RFFR_ST_AVG_OC_BIT      5
`define RFFR_ST_FLY_SHORT_BIT   4
`define RFFR_FLYAVG_WMASK       8'hB3

// Reset values
`define RFFR_CFG_RESET          8'h00

// Response codes after decoding
`define RFFR_ACT_FLAG           2'h0
`define RFFR_ACT_HICCUP         2'h1
`define RFFR_ACT_LATCH          2'h2

// Timing
`define RFFR_CLK_MHZ            200
`define RFFR_HICCUP_MS          500

`endif

// *** sim/rffr_fault_response_assertions.sv ***
// Checker for the fault-response block, bound to its top module.
// Assumes clkEnable is high through reset and pins are spaced by the bench.
`timescale 1ns/100ps
module rffr_fault_response_assertions (
	input logic       clk,
	input logic       reset,
	input logic       clkEnable,
	input logic       sixVoltOver,
	input logic       sixVoltUnder,
	input logic       flybackOver,
	input logic       avgOverCurrent,
	input logic       flybackShort,
	input logic       pwmEnablePin,
	input logic       chipEnablePin,
	input logic [7:0] regAddr,
	input logic       regRead,
	input logic [7:0] regRdData,
	input logic       pwmRun,
	input logic       flybackRun,
	input logic       fault_alert_n,
	input logic       system_fail_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	wire anyFault = sixVoltOver | sixVoltUnder | flybackOver | avgOverCurrent | flybackShort;
	wire rdTake = regRead & clkEnable;
	// Four samples cover two synchroniser flops plus the output flop
	sequence faultHeld; (anyFault && clkEnable)[*4]; endsequence
	sequence chipOff; (!chipEnablePin && clkEnable)[*4]; endsequence
	sequence pwmOff; (!pwmEnablePin && clkEnable)[*4]; endsequence
	alert_on_fault_a: assert property (faultHeld |=> !fault_alert_n)
		else $error("alert not low under fault");
	reset_state_a: assert property ($fell(reset) |-> regRdData == 8'h00 && !pwmRun && fault_alert_n)
		else $error("outputs wrong after reset");
	pwm_needs_fly_a: assert property ((!flybackRun && clkEnable)[*2] |-> !pwmRun)
		else $error("pwm runs without flyback");
	chip_off_a: assert property (chipOff |=> !pwmRun)
		else $error("pwm runs with chip disabled");
	pwm_off_a: assert property (pwmOff |=> !pwmRun)
		else $error("pwm runs with pwm disabled");
	fail_halt_a: assert property (!system_fail_n && clkEnable |=> !pwmRun && !flybackRun)
		else $error("switching during system fail");
	flyavg_reserved_a: assert property (rdTake && regAddr == 8'hB4 |-> ##2 regRdData[6] == 1'b0 && regRdData[3:2] == 2'h0)
		else $error("reserved bits read nonzero");
	override_reserved_a: assert property (rdTake && regAddr == 8'hB0 |-> ##2 regRdData[6:0] == 7'h00)
		else $error("override register low bits nonzero");
	unmapped_read_a: assert property (rdTake && regAddr == 8'hB5 |-> ##2 regRdData == 8'h00)
		else $error("unmapped read nonzero");
endmodule

// *** sim/rffr_stage_model.sv ***
// Power stage and controller model: fault detectors and enable pins.
// Assumes the bench steers it through faultReq and restartReq on clk.
`timescale 1ns/100ps
module rffr_stage_model (
	input  logic       clk,
	input  logic [4:0] faultReq,
	input  logic       restartReq,
	output logic       sixVoltOver,
	output logic       sixVoltUnder,
	output logic       flybackOver,
	output logic       avgOverCurrent,
	output logic       flybackShort,
	output logic       chipEnablePin,
	output logic       pwmEnablePin
);
	logic [3:0] railWait;
	initial begin
		{flybackShort, avgOverCurrent, flybackOver, sixVoltUnder, sixVoltOver} = 5'h00;
		chipEnablePin = 1'b1;
		pwmEnablePin = 1'b1;
		railWait = 4'hF;
	end
	always @(posedge clk) begin
		{flybackShort, avgOverCurrent, flybackOver, sixVoltUnder, sixVoltOver} <= faultReq;
		chipEnablePin <= !restartReq;
		// PWM enable comes back late, after the rails have had time to settle
		railWait <= {railWait[2:0], !restartReq};
		pwmEnablePin <= &railWait;
	end
endmodule

// *** sim/rail_flyback_fault_response_test.sv ***
// Self-checking bench for the rail and flyback fault-response block.
// Assumes the stage model and the checker from the same folder.
`timescale 1ns/100ps
module rail_flyback_fault_response_test;
	localparam HIC = 20;
	logic       clk, reset, clkEnable, writeProtect, regWrite, regRead, restartReq, rdDue, pinDue;
	logic       sixVoltOver, sixVoltUnder, flybackOver, avgOverCurrent, flybackShort;
	logic       pwmEnablePin, chipEnablePin, pwmRun, flybackRun, fault_alert_n, system_fail_n;
	logic [1:0] modeStrap;
	logic [4:0] faultReq;
	logic [3:0] e;
	logic [7:0] regAddr, regWrData, regRdData, v;
	logic [7:0] rdQ[$];
	logic [3:0] pinQ[$];
	int         bad_count, tests_run;
	logic [7:0] cfgA[4] = '{8'hB3, 8'hB3, 8'hB4, 8'hB4};
	logic [7:0] stA[4] = '{8'hD3, 8'hD3, 8'hD3, 8'hD5};
	logic [7:0] stV[4] = '{8'h01, 8'h02, 8'h10, 8'h20};
	int         sh[4] = '{4, 6, 0, 4};

	rffr_fault_response #(.HICCUP_CYCLES(HIC)) rffr_fault_response_i (.clk(clk), .reset(reset),
		.clkEnable(clkEnable), .sixVoltOver(sixVoltOver), .sixVoltUnder(sixVoltUnder), .flybackOver(flybackOver),
		.avgOverCurrent(avgOverCurrent), .flybackShort(flybackShort), .pwmEnablePin(pwmEnablePin),
		.chipEnablePin(chipEnablePin), .modeStrap(modeStrap), .writeProtect(writeProtect), .regAddr(regAddr),
		.regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .pwmRun(pwmRun),
		.flybackRun(flybackRun), .fault_alert_n(fault_alert_n), .system_fail_n(system_fail_n));
	rffr_stage_model rffr_stage_model_i (.clk(clk), .faultReq(faultReq), .restartReq(restartReq),
		.sixVoltOver(sixVoltOver), .sixVoltUnder(sixVoltUnder), .flybackOver(flybackOver),
		.avgOverCurrent(avgOverCurrent), .flybackShort(flybackShort), .chipEnablePin(chipEnablePin),
		.pwmEnablePin(pwmEnablePin));

	task check(input logic [7:0] s, input logic [7:0] x);
		tests_run++;
		if (s !== x) begin
			bad_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, x);
		end
	endtask
	task print_verdict;
		$display("Counts: %0d compared, %0d mismatched", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask
	// Data is compared two edges after the read is taken, so either read latency passes
	task rd(input logic [7:0] a, input logic [7:0] x);
		@(posedge clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		@(posedge clk);
		rdQ.push_back(x);
		rdDue <= 1'b1;
		@(posedge clk);
		rdDue <= 1'b0;
	endtask
	task probe(input logic [3:0] x);
		@(posedge clk);
		pinQ.push_back(x);
		pinDue <= 1'b1;
		@(posedge clk);
		pinDue <= 1'b0;
	endtask
	task waitPwm;
		int n;
		n = 0;
		while (pwmRun !== 1'b1 && n < 200) begin
			@(posedge clk);
			n++;
		end
		if (n >= 200) begin
			bad_count++;
			$display("[FAIL] %0t pwm never resumed", $time);
			print_verdict;
		end
	endtask
	task hit(input int b, input logic [7:0] ca, cv, sa, sv, input logic [3:0] x, f);
		wr(ca, cv);
		faultReq[b] <= 1'b1;
		repeat (6) @(posedge clk);
		probe(x);
		rd(sa, sv);
		faultReq <= 5'h00;
		repeat (8) @(posedge clk);
		probe(x);
		repeat (HIC + 12) @(posedge clk);
		probe(f);
		wr(sa, 8'hFF);
		rd(sa, 8'h00);
		restartReq <= 1'b1;
		repeat (5) @(posedge clk);
		restartReq <= 1'b0;
		waitPwm;
		probe(4'hF);
	endtask

	always @(posedge clk) begin
		if (rdDue === 1'b1) check(regRdData, rdQ.pop_front());
		if (pinDue === 1'b1) check({4'h0, fault_alert_n, pwmRun, flybackRun, system_fail_n}, {4'h0, pinQ.pop_front()});
	end
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		{reset, clkEnable, writeProtect, regWrite, regRead, restartReq, rdDue, pinDue} = 8'hC0;
		{modeStrap, faultReq, regAddr, regWrData} = 23'h0;
		bad_count = 0;
		tests_run = 0;
		void'($urandom(32'h53A6B068));
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		rd(8'hB3, 8'h00);
		rd(8'hB4, 8'h00);
		rd(8'hB0, 8'h00);
		clkEnable <= 1'b0;
		repeat (3) @(posedge clk);
		clkEnable <= 1'b1;
		waitPwm;
		probe(4'hF);
		$display("reset test done");
		repeat (4) begin
			v = 8'($urandom);
			wr(8'hB3, v);
			rd(8'hB3, v);
			wr(8'hB4, v);
			rd(8'hB4, v & 8'hB3);
			writeProtect <= 1'b1;
			wr(8'hB3, ~v);
			rd(8'hB3, v);
			writeProtect <= 1'b0;
		end
		rd(8'hB5, 8'h00);
		$display("register test done");
		wr(8'hB0, 8'h80);
		rd(8'hB0, 8'h80);
		writeProtect <= 1'b1;
		wr(8'hB0, 8'h00);
		rd(8'hB0, 8'h80);
		writeProtect <= 1'b0;
		for (int i = 0; i < 4; i++)
			for (int c = 0; c < 4; c++) begin
				e = (c == 1 || c == 2) ? ((i == 2) ? 4'h1 : 4'h3) : 4'h7;
				hit(i, cfgA[i], 8'(c << sh[i]), stA[i], stV[i], e, (c == 2) ? e : 4'h7);
			end
		hit(4, 8'hB4, 8'h00, 8'hD8, 8'h10, 4'h0, 4'h0);
		hit(4, 8'hB4, 8'h80, 8'hD8, 8'h10, 4'h7, 4'h7);
		$display("response test done");
		wr(8'hB0, 8'h00);
		hit(0, 8'hB3, 8'h10, 8'hD3, 8'h01, 4'h7, 4'h7);
		modeStrap <= 2'h2;
		hit(0, 8'hB3, 8'h10, 8'hD3, 8'h01, 4'h3, 4'h3);
		$display("override test done");
		print_verdict;
	end
endmodule

bind rffr_fault_response rffr_fault_response_assertions rffr_fault_response_assertions_i (.clk(clk), .reset(reset),
	.clkEnable(clkEnable), .sixVoltOver(sixVoltOver), .sixVoltUnder(sixVoltUnder), .flybackOver(flybackOver),
	.avgOverCurrent(avgOverCurrent), .flybackShort(flybackShort), .pwmEnablePin(pwmEnablePin),
	.chipEnablePin(chipEnablePin), .regAddr(regAddr), .regRead(regRead), .regRdData(regRdData), .pwmRun(pwmRun),
	.flybackRun(flybackRun), .fault_alert_n(fault_alert_n), .system_fail_n(system_fail_n));
